// ===== core/acs_top.sv
// converter reference, channel selection and result register block
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - finished result lands in both result bytes, valid once flag high
// - single ended result unsigned, 0x000 ground to 0x3FF
// - differential result two's complement, 0x200 to 0x1FF, saturating
// - reference field: 00 external pin, 01 supply, 10 reserved, 11 internal
// - reference change during conversion waits for the done flag
// - alignment bit five set gives left aligned bytes, clear right aligned
// - alignment change reformats result bytes at once
// - selection register eight bits read/write, reset zero
// - result bytes read only, layout follows alignment
// - channel field picks pairing, changes wait for conversion end
module acs_top (
    // ************************************************************
    // clock and reset
    // ************************************************************
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst,
    // ************************************************************
    // axi4-lite write address and data
    // ************************************************************
    input  wire logic                       i_axi_awvalid,
    output      logic                       o_axi_awready,
    input  wire logic [acs_pkg::ADDR_W-1:0] i_axi_awaddr,
    input  wire logic [2:0]                 i_axi_awprot,
    input  wire logic                       i_axi_wvalid,
    output      logic                       o_axi_wready,
    input  wire logic [acs_pkg::DATA_W-1:0] i_axi_wdata,
    input  wire logic [3:0]                 i_axi_wstrb,
    // ************************************************************
    // axi4-lite write response
    // ************************************************************
    output      logic                       o_axi_bvalid,
    input  wire logic                       i_axi_bready,
    output      logic [1:0]                 o_axi_bresp,
    // ************************************************************
    // axi4-lite read
    // ************************************************************
    input  wire logic                       i_axi_arvalid,
    output      logic                       o_axi_arready,
    input  wire logic [acs_pkg::ADDR_W-1:0] i_axi_araddr,
    input  wire logic [2:0]                 i_axi_arprot,
    output      logic                       o_axi_rvalid,
    input  wire logic                       i_axi_rready,
    output      logic [acs_pkg::DATA_W-1:0] o_axi_rdata,
    output      logic [1:0]                 o_axi_rresp,
    // ************************************************************
    // converter core side
    // ************************************************************
    output      logic                       o_conv_start,
    output      logic                       o_conv_busy,
    input  wire logic                       i_conv_done,
    input  wire logic [acs_pkg::RAW_W-1:0]  i_conv_raw,
    // ************************************************************
    // analog routing controls
    // ************************************************************
    output      logic                       o_ref_ext_sel,
    output      logic                       o_ref_supply_sel,
    output      logic                       o_ref_int_on,
    output      logic [4:0]                 o_channel_select,
    output      logic                       o_diff_mode,
    // ************************************************************
    // interrupt
    // ************************************************************
    output      logic                       o_irq
);
    import acs_pkg::*;

    // ************************************************************
    // helper functions
    // ************************************************************
    function automatic logic [IDX_W-1:0] acs_index(
        input logic [ADDR_W-1:0] addr
    );
        acs_index = addr[ADDR_W-1:IDX_LSB];
    endfunction

    function automatic logic acs_is_diff(input logic [4:0] chan);
        acs_is_diff = chan[CHAN_MSB] && (chan != CHAN_BGAP)
                      && (chan != CHAN_GND);
    endfunction

    // raw is a signed count in 1/1024 steps of the reference
    function automatic logic [RES_W-1:0] acs_code(
        input logic [RAW_W-1:0] raw,
        input logic             diff
    );
        logic signed [RAW_W-1:0] s;
        logic signed [RAW_W-1:0] h;
        s = raw;
        h = s >>> 1;
        acs_code = SE_MIN;
        if (diff) begin
            // half scale: 512 steps per reference
            if (h > $signed(12'h1FF)) begin
                acs_code = DIFF_MAX;
            end else if (h < $signed(12'hE00)) begin
                acs_code = DIFF_MIN;
            end else begin
                acs_code = h[RES_W-1:0];
            end
        end else begin
            if (s < $signed(12'h000)) begin
                acs_code = SE_MIN;
            end else if (s > $signed(12'h3FF)) begin
                acs_code = SE_MAX;
            end else begin
                acs_code = s[RES_W-1:0];
            end
        end
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************
    logic              aw_hold_q;
    logic              aw_hold_d;
    logic [IDX_W-1:0]  aw_idx_q;
    logic [IDX_W-1:0]  aw_idx_d;
    logic              w_hold_q;
    logic              w_hold_d;
    logic [7:0]        wdata_q;
    logic [7:0]        wdata_d;
    logic              wstrb_q;
    logic              wstrb_d;
    logic              bvalid_q;
    logic              bvalid_d;
    logic [1:0]        bresp_q;
    logic [1:0]        bresp_d;
    logic              wr_do;
    logic              rvalid_q;
    logic              rvalid_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [1:0]        rresp_q;
    logic [1:0]        rresp_d;
    logic [IDX_W-1:0]  ar_idx;
    logic              wr_sel;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_mask;
    logic [7:0]        select_q;
    logic [7:0]        select_d;
    logic [1:0]        act_ref_q;
    logic [1:0]        act_ref_d;
    logic [4:0]        act_chan_q;
    logic [4:0]        act_chan_d;
    acs_state_t        state_q;
    acs_state_t        state_d;
    logic              start_q;
    logic              start_d;
    logic [RES_W-1:0]  result_q;
    logic [RES_W-1:0]  result_d;
    logic [EV_W-1:0]   stat_q;
    logic [EV_W-1:0]   stat_d;
    logic [EV_W-1:0]   mask_q;
    logic [EV_W-1:0]   mask_d;
    logic              done_ev;

    acs_res_if res ();

    // ************************************************************
    // result formatter
    // ************************************************************
    acs_fmt u_fmt (
        .res (res)
    );

    assign res.result     = result_q;
    assign res.left_align = select_q[ALIGN_BIT];

    // ************************************************************
    // write channel, address and data taken in either order
    // ************************************************************
    assign o_axi_awready = !aw_hold_q;
    assign o_axi_wready  = !w_hold_q;
    assign wr_do         = aw_hold_q && w_hold_q && !bvalid_q;

    always_comb begin
        aw_hold_d = aw_hold_q;
        aw_idx_d  = aw_idx_q;
        w_hold_d  = w_hold_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (bvalid_q && i_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_do) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            unique case (aw_idx_q)
                IDX_SELECT, IDX_CTRL, IDX_STAT, IDX_MASK,
                IDX_RES_LO, IDX_RES_HI: begin
                    bresp_d = RESP_OKAY;
                end
                default: begin
                    bresp_d = RESP_SLVERR;
                end
            endcase
        end
        if (i_axi_awvalid && !aw_hold_q) begin
            aw_hold_d = 1'b1;
            aw_idx_d  = acs_index(i_axi_awaddr);
        end
        if (i_axi_wvalid && !w_hold_q) begin
            w_hold_d = 1'b1;
            wdata_d  = i_axi_wdata[7:0];
            wstrb_d  = i_axi_wstrb[0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_hold_q <= 1'b0;
            aw_idx_q  <= '0;
            w_hold_q  <= 1'b0;
            wdata_q   <= 8'h00;
            wstrb_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            aw_idx_q  <= aw_idx_d;
            w_hold_q  <= w_hold_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    assign o_axi_bvalid = bvalid_q;
    assign o_axi_bresp  = bresp_q;

    // writes to result bytes are accepted and ignored
    assign wr_sel  = wr_do && wstrb_q && (aw_idx_q == IDX_SELECT);
    assign wr_ctrl = wr_do && wstrb_q && (aw_idx_q == IDX_CTRL);
    assign wr_stat = wr_do && wstrb_q && (aw_idx_q == IDX_STAT);
    assign wr_mask = wr_do && wstrb_q && (aw_idx_q == IDX_MASK);

    // ************************************************************
    // read channel
    // ************************************************************
    assign o_axi_arready = !rvalid_q;
    assign ar_idx        = acs_index(i_axi_araddr);

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && i_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (i_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = '0;
            unique case (ar_idx)
                IDX_SELECT: begin
                    rdata_d[7:0] = select_q;
                end
                IDX_RES_LO: begin
                    rdata_d[7:0] = res.low_byte;
                end
                IDX_RES_HI: begin
                    rdata_d[7:0] = res.high_byte;
                end
                IDX_CTRL: begin
                    rdata_d[CTRL_START] = (state_q == ACS_CONV);
                end
                IDX_STAT: begin
                    rdata_d[EV_W-1:0] = stat_q;
                end
                IDX_MASK: begin
                    rdata_d[EV_W-1:0] = mask_q;
                end
                default: begin
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign o_axi_rvalid = rvalid_q;
    assign o_axi_rdata  = rdata_q;
    assign o_axi_rresp  = rresp_q;

    // ************************************************************
    // selection, conversion sequencing, result and events
    // ************************************************************
    assign done_ev = (state_q == ACS_CONV) && i_conv_done;

    always_comb begin
        select_d   = select_q;
        act_ref_d  = act_ref_q;
        act_chan_d = act_chan_q;
        state_d    = state_q;
        start_d    = 1'b0;
        result_d   = result_q;
        stat_d     = stat_q;
        mask_d     = mask_q;
        if (wr_sel) begin
            select_d = wdata_q;
        end
        if (wr_mask) begin
            mask_d = wdata_q[EV_W-1:0];
        end
        if (wr_stat) begin
            stat_d = stat_q & ~wdata_q[EV_W-1:0];
        end
        unique case (state_q)
            ACS_IDLE: begin
                // shadow tracks the register while nothing converts
                act_ref_d  = select_q[REF_MSB:REF_LSB];
                act_chan_d = select_q[CHAN_MSB:0];
                if (wr_ctrl && wdata_q[CTRL_START]) begin
                    state_d = ACS_CONV;
                    start_d = 1'b1;
                end
            end
            ACS_CONV: begin
                // shadow locked, so a late write waits for completion
                if (i_conv_done) begin
                    state_d    = ACS_IDLE;
                    result_d   = acs_code(i_conv_raw,
                                          acs_is_diff(act_chan_q));
                    act_ref_d  = select_q[REF_MSB:REF_LSB];
                    act_chan_d = select_q[CHAN_MSB:0];
                end
            end
        endcase
        // set beats a clear in the same cycle
        if (done_ev) begin
            stat_d[EV_DONE] = 1'b1;
            if (stat_q[EV_DONE]) begin
                stat_d[EV_OVER] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            select_q   <= SELECT_RST;
            act_ref_q  <= SELECT_RST[REF_MSB:REF_LSB];
            act_chan_q <= SELECT_RST[CHAN_MSB:0];
            state_q    <= ACS_IDLE;
            start_q    <= 1'b0;
            result_q   <= RES_RST;
            stat_q     <= EV_RST;
            mask_q     <= EV_RST;
        end else begin
            select_q   <= select_d;
            act_ref_q  <= act_ref_d;
            act_chan_q <= act_chan_d;
            state_q    <= state_d;
            start_q    <= start_d;
            result_q   <= result_d;
            stat_q     <= stat_d;
            mask_q     <= mask_d;
        end
    end

    // ************************************************************
    // analog routing decode
    // ************************************************************
    // reserved code leaves every reference switch open
    always_comb begin
        o_ref_ext_sel    = 1'b0;
        o_ref_supply_sel = 1'b0;
        o_ref_int_on     = 1'b0;
        unique case (act_ref_q)
            REF_EXT: begin
                o_ref_ext_sel = 1'b1;
            end
            REF_SUPPLY: begin
                o_ref_supply_sel = 1'b1;
            end
            REF_RSVD: begin
                o_ref_ext_sel = 1'b0;
            end
            REF_INT: begin
                o_ref_int_on = 1'b1;
            end
        endcase
    end

    assign o_channel_select = act_chan_q;
    assign o_diff_mode      = acs_is_diff(act_chan_q);
    assign o_conv_start     = start_q;
    assign o_conv_busy      = (state_q == ACS_CONV);
    assign o_irq            = |(stat_q & mask_q);

endmodule

// ===== pkg/acs_pkg.sv
// constants and types for the converter selection and result block
package acs_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam int          IDX_W       = 10;
    localparam int          IDX_LSB     = 2;

    // ************************************************************
    // register indices, byte address is four times the index
    // ************************************************************
    localparam logic [9:0]  IDX_RES_LO  = 10'h078;
    localparam logic [9:0]  IDX_RES_HI  = 10'h079;
    localparam logic [9:0]  IDX_SELECT  = 10'h07C;
    localparam logic [9:0]  IDX_CTRL    = 10'h070;
    localparam logic [9:0]  IDX_STAT    = 10'h071;
    localparam logic [9:0]  IDX_MASK    = 10'h072;

    // ************************************************************
    // selection register fields and reset
    // ************************************************************
    localparam int          REF_MSB     = 7;
    localparam int          REF_LSB     = 6;
    localparam int          ALIGN_BIT   = 5;
    localparam int          CHAN_MSB    = 4;
    localparam logic [7:0]  SELECT_RST  = 8'h00;

    // reference select encodings
    localparam logic [1:0]  REF_EXT     = 2'h0;
    localparam logic [1:0]  REF_SUPPLY  = 2'h1;
    localparam logic [1:0]  REF_RSVD    = 2'h2;
    localparam logic [1:0]  REF_INT     = 2'h3;

    // channel codes that stay single ended despite bit 4
    localparam logic [4:0]  CHAN_BGAP   = 5'h1E;
    localparam logic [4:0]  CHAN_GND    = 5'h1F;

    // ************************************************************
    // control and event bits
    // ************************************************************
    localparam int          CTRL_START  = 0;
    localparam int          EV_W        = 2;
    localparam int          EV_DONE     = 0;
    localparam int          EV_OVER     = 1;
    localparam logic [1:0]  EV_RST      = 2'h0;

    // ************************************************************
    // result coding
    // ************************************************************
    localparam int          RAW_W       = 12;
    localparam int          RES_W       = 10;
    localparam logic [9:0]  SE_MIN      = 10'h000;
    localparam logic [9:0]  SE_MAX      = 10'h3FF;
    localparam logic [9:0]  DIFF_MAX    = 10'h1FF;
    localparam logic [9:0]  DIFF_MIN    = 10'h200;
    localparam logic [9:0]  RES_RST     = 10'h000;

    // bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic {
        ACS_IDLE,
        ACS_CONV
    } acs_state_t;

endpackage

// ===== pkg/acs_res_if.sv
// carrier between the control core and the result formatter
`timescale 1ns/1ps
interface acs_res_if;
    logic [9:0] result;
    logic       left_align;
    logic [7:0] high_byte;
    logic [7:0] low_byte;

    modport core (
        output result,
        output left_align,
        input  high_byte,
        input  low_byte
    );

    modport fmt (
        input  result,
        input  left_align,
        output high_byte,
        output low_byte
    );
endinterface

// ===== core/acs_fmt.sv
// result byte pair formatter, left or right aligned
`timescale 1ns/1ps
module acs_fmt (
    // ************************************************************
    // result and alignment in, bytes out
    // ************************************************************
    acs_res_if.fmt  res
);
    import acs_pkg::*;

    // purely combinational so an alignment change shows at once
    always_comb begin
        if (res.left_align) begin
            res.high_byte = res.result[9:2];
            res.low_byte  = {res.result[1:0], 6'h00};
        end else begin
            res.high_byte = {6'h00, res.result[9:8]};
            res.low_byte  = res.result[7:0];
        end
    end
endmodule

// ===== verification/acs_conv_model.sv
// behavioural converter core answering start with a delayed done pulse
`timescale 1ns/1ps
module acs_conv_model (
    input  wire logic        i_clk, i_rst, i_start,
    input  wire logic [7:0]  i_lat,
    input  wire logic [11:0] i_val,
    output      logic        o_done,
    output      logic [11:0] o_raw
);
    logic [7:0] cnt_q;
    logic       run_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_q  <= 1'h0;
            cnt_q  <= 8'h00;
            o_done <= 1'h0;
        end else begin
            o_done <= 1'h0;
            if (i_start) begin
                run_q <= 1'h1;
                cnt_q <= i_lat;
            end else if (run_q) begin
                if (cnt_q == 8'h00) begin
                    run_q  <= 1'h0;
                    o_done <= 1'h1;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
        end
    end

    // sample only valid on the done cycle, garbage otherwise
    assign o_raw = o_done ? i_val : ~i_val;
endmodule

// ===== verification/acs_top_assertions.sv
// port level assertions for the selection and result block
`timescale 1ns/1ps
module acs_top_assertions (
    input wire logic        i_ref_clk, i_rst, o_axi_bvalid, i_axi_bready,
    input wire logic        o_axi_rvalid, i_axi_rready, o_conv_start,
    input wire logic        o_conv_busy, i_conv_done, o_ref_ext_sel,
    input wire logic        o_ref_supply_sel, o_ref_int_on, o_diff_mode,
    input wire logic [1:0]  o_axi_bresp,
    input wire logic [31:0] o_axi_rdata,
    input wire logic [4:0]  o_channel_select
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_start_pulse;
        $rose(o_conv_busy) |-> o_conv_start ##1 !o_conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse wrong");
    property p_done_idle;
        o_conv_busy && i_conv_done |=> !o_conv_busy;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("busy after done");
    property p_ref_frozen;
        o_conv_busy ##1 o_conv_busy
            |-> $stable({o_ref_ext_sel, o_ref_supply_sel, o_ref_int_on});
    endproperty
    a_ref_frozen: assert property (p_ref_frozen)
        else $error("ref moved");
    property p_chan_frozen;
        o_conv_busy ##1 o_conv_busy |-> $stable(o_channel_select);
    endproperty
    a_chan_frozen: assert property (p_chan_frozen)
        else $error("chan moved");
    property p_ref_onehot;
        $onehot0({o_ref_ext_sel, o_ref_supply_sel, o_ref_int_on});
    endproperty
    a_ref_onehot: assert property (p_ref_onehot)
        else $error("two references on");
    property p_diff_decode;
        o_diff_mode == (o_channel_select[4] && o_channel_select < 5'h1E);
    endproperty
    a_diff_decode: assert property (p_diff_decode)
        else $error("diff decode");
    property p_bresp_hold;
        o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("bresp dropped");
    property p_rdata_hold;
        o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data dropped");
endmodule

bind acs_top acs_top_assertions u_acs_top_assertions (.i_ref_clk, .i_rst,
    .o_axi_bvalid, .i_axi_bready, .o_axi_bresp, .o_axi_rvalid, .i_axi_rready,
    .o_axi_rdata, .o_conv_start, .o_conv_busy, .i_conv_done, .o_ref_ext_sel,
    .o_ref_supply_sel, .o_ref_int_on, .o_channel_select, .o_diff_mode);

// ===== verification/testbench.sv
// register level testbench for the selection and result block
`timescale 1ns/1ps
module testbench;
    import acs_pkg::*;
    localparam logic [11:0] A_SEL = {IDX_SELECT, 2'h0}, A_LO = {IDX_RES_LO, 2'h0},
        A_HI = {IDX_RES_HI, 2'h0}, A_CTL = {IDX_CTRL, 2'h0},
        A_STA = {IDX_STAT, 2'h0}, A_MSK = {IDX_MASK, 2'h0};
    logic i_ref_clk = 1'h0, i_rst = 1'h1, i_axi_awvalid = 1'h0;
    logic i_axi_wvalid = 1'h0, i_axi_bready = 1'h0, i_axi_arvalid = 1'h0;
    logic i_axi_rready = 1'h0, o_axi_awready, o_axi_wready, o_axi_bvalid;
    logic o_axi_arready, o_axi_rvalid, o_conv_start, o_conv_busy, o_irq;
    logic i_conv_done, o_ref_ext_sel, o_ref_supply_sel, o_ref_int_on;
    logic o_diff_mode;
    logic [11:0] i_axi_awaddr = 12'h000, i_axi_araddr = 12'h000;
    logic [31:0] i_axi_wdata = 32'h0, o_axi_rdata, d;
    logic [2:0] i_axi_awprot = 3'h0, i_axi_arprot = 3'h0;
    logic [3:0] i_axi_wstrb = 4'hF;
    logic [1:0] o_axi_bresp, o_axi_rresp, r;
    logic [11:0] i_conv_raw, val = 12'h000;
    logic [4:0] o_channel_select;
    logic [7:0] lat = 8'h03;
    logic [2:0] rtab [4] = '{3'h4, 3'h2, 3'h0, 3'h1};
    logic [4:0] ch [7] = '{5'h00, 5'h00, 5'h00, 5'h10, 5'h10, 5'h10, 5'h1E};
    logic [11:0] raw [7] = '{12'h155, 12'h7FF, 12'hF00, 12'hF46, 12'h7FF,
                             12'h800, 12'h020};
    logic [9:0] ex [7] = '{10'h155, 10'h3FF, 10'h000, 10'h3A3, 10'h1FF,
                           10'h200, 10'h020};
    int miscompares = 0, n_compared = 0, cyc = 0, i;

    acs_top u_acs_top (.*);
    acs_conv_model u_acs_conv_model (.i_clk(i_ref_clk), .i_rst(i_rst),
        .i_start(o_conv_start), .o_done(i_conv_done), .i_lat(lat),
        .i_val(val), .o_raw(i_conv_raw));

    always #2 i_ref_clk = ~i_ref_clk;
    // hang guard
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic nap(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bit fa = 1'b0, fw = 1'b0;
        i_axi_awaddr <= a;
        i_axi_wdata <= v;
        i_axi_awvalid <= 1'h1;
        i_axi_wvalid <= 1'h1;
        i_axi_bready <= 1'h1;
        do begin
            @(posedge i_ref_clk);
            fa |= o_axi_awready;
            fw |= o_axi_wready;
            if (fa) i_axi_awvalid <= 1'h0;
            if (fw) i_axi_wvalid <= 1'h0;
        end while (!(fa && fw));
        do @(posedge i_ref_clk); while (o_axi_bvalid !== 1'h1);
        r = o_axi_bresp;
        i_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a);
        i_axi_araddr <= a;
        i_axi_arvalid <= 1'h1;
        i_axi_rready <= 1'h1;
        do @(posedge i_ref_clk); while (o_axi_arready !== 1'h1);
        i_axi_arvalid <= 1'h0;
        do @(posedge i_ref_clk); while (o_axi_rvalid !== 1'h1);
        d = o_axi_rdata;
        r = o_axi_rresp;
        i_axi_rready <= 1'h0;
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'h0;
        @(posedge i_ref_clk);
        // ************************************************************
        // register map
        // ************************************************************
        rd(A_SEL); chk("select reset", d, 32'h0);
        wr(A_SEL, 32'hFFFFFFFF); rd(A_SEL); chk("select rw", d, 32'hFF);
        rd(12'h000); chk("unmapped", 32'(r), 32'(RESP_SLVERR));
        wr(A_LO, 32'hFF); chk("ro okay", 32'(r), 32'(RESP_OKAY));
        rd(A_LO); chk("result ro", d, 32'h0);
        $display("map test done");
        // external pin left undriven
        for (i = 0; i < 4; i++) begin
            wr(A_SEL, i << 6); nap(2);
            chk("ref decode", 32'({o_ref_ext_sel, o_ref_supply_sel,
                o_ref_int_on}), 32'(rtab[i]));
        end
        $display("reference test done");
        wr(A_MSK, 32'h1);
        for (i = 0; i < 7; i++) begin
            lat <= 8'(3 + i);
            val <= raw[i];
            wr(A_SEL, 32'h40 | ch[i]); wr(A_CTL, 32'h1);
            repeat (60) if (o_irq !== 1'h1) @(posedge i_ref_clk);
            chk("irq", 32'(o_irq), 32'h1);
            chk("diff", 32'(o_diff_mode), 32'(ch[i] == 5'h10));
            rd(A_STA); chk("done flag", 32'(d[0]), 32'h1);
            rd(A_HI); chk("right high", d, 32'(ex[i][9:8]));
            rd(A_LO); chk("right low", d, 32'(ex[i][7:0]));
            wr(A_SEL, 32'h60 | ch[i]);
            rd(A_HI); chk("left high", d, 32'(ex[i][9:2]));
            rd(A_LO); chk("left low", d, {24'h0, ex[i][1:0], 6'h0});
            wr(A_STA, 32'h1); nap(1);
            chk("irq clear", 32'(o_irq), 32'h0);
        end
        $display("coding test done");
        wr(A_SEL, 32'h40); wr(A_MSK, 32'h0);
        lat <= 8'd40;
        val <= 12'h155;
        wr(A_CTL, 32'h1); wr(A_SEL, 32'hF0); nap(1);
        chk("ref held", 32'({o_ref_supply_sel, o_ref_int_on}), 32'h2);
        chk("chan held", 32'(o_channel_select), 32'h0);
        rd(A_CTL); chk("busy", 32'(d[0]), 32'h1);
        rd(A_HI); chk("align at once", d, 32'(ex[6][9:2]));
        repeat (80) if (o_conv_busy !== 1'h0) @(posedge i_ref_clk);
        nap(2);
        chk("ref applied", 32'(o_ref_int_on), 32'h1);
        chk("chan applied", 32'(o_channel_select), 32'h10);
        chk("irq masked", 32'(o_irq), 32'h0);
        rd(A_HI); chk("old channel used", d, 32'h55);
        wr(A_MSK, 32'h1); nap(1); chk("irq unmasked", 32'(o_irq), 32'h1);
        wr(A_STA, 32'h1);
        $display("deferral test done");
        give_verdict();
    end
endmodule
